// file: verilog/tmpc_pkg.sv
// Package: register map, field positions, reset values and carriers of the timer block
package tmpc_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets (one aligned 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRLA    = 8'h00;
  localparam logic [7:0] OFF_CTRL_CLR = 8'h04;
  localparam logic [7:0] OFF_CTRL_SET = 8'h08;
  localparam logic [7:0] OFF_CTRLC    = 8'h0C;
  localparam logic [7:0] OFF_EVCTRL   = 8'h10;
  localparam logic [7:0] OFF_IEN_CLR  = 8'h14;
  localparam logic [7:0] OFF_IEN_SET  = 8'h18;
  localparam logic [7:0] OFF_IFLAG    = 8'h1C;
  localparam logic [7:0] OFF_STATUS   = 8'h20;
  localparam logic [7:0] OFF_COUNT    = 8'h24;
  localparam logic [7:0] OFF_PERIOD   = 8'h28;
  localparam logic [7:0] OFF_CCV0     = 8'h2C;
  localparam logic [7:0] OFF_CCV1     = 8'h30;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRLA_EN      = 0;
  localparam int CTRLA_WAVE_LO = 1;
  localparam int CTRLB_DIR     = 0;
  localparam int CTRLB_SINGLE  = 2;
  localparam int CTRLB_CMD_LO  = 6;
  localparam int EV_ACT_LO     = 0;
  localparam int EV_INV        = 4;
  localparam int EV_IN_EN      = 5;
  localparam int IF_OVF        = 0;
  localparam int IF_ERR        = 1;
  localparam int IF_SYNC       = 3;
  localparam int IF_MC0        = 4;
  localparam int STAT_STOP     = 3;

  // Commands and event actions
  localparam logic [1:0] CMD_RETRIG  = 2'h1;
  localparam logic [1:0] CMD_STOP    = 2'h2;
  localparam logic [2:0] ACT_RETRIG  = 3'h1;
  localparam logic [2:0] ACT_COUNT   = 3'h2;
  localparam logic [2:0] ACT_START   = 3'h3;
  localparam logic [2:0] ACT_PPW     = 3'h4;
  localparam logic [2:0] ACT_PWP     = 3'h5;

  // Reset values
  localparam logic [7:0] RST_PERIOD = 8'hFF;
  localparam logic [7:0] RST_ZERO8  = 8'h00;

  typedef enum logic [1:0] {
    normal_frequency_mode = 2'h0,
    match_frequency_mode  = 2'h1,
    normal_pwm_mode       = 2'h2,
    match_pwm_mode        = 2'h3
  } tmpc_wave_e;

  // DMA request group
  typedef struct packed {
    logic       ovf;
    logic [1:0] chan;
  } tmpc_dma_s;

endpackage

// file: verilog/tmpc_top.sv
// Timer block: match PWM, TOP selection, capture, single run, DMA and interrupt flags
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps
// What this block does
// - Match PWM drives output 1 from channel 1, low pulse on output 0 at wrap.
// - TOP is period value in normal modes, compare value 0 in match modes.
// - Updates at TOP or zero; overflow flag at TOP up, zero down.
// - TOP rewritten near zero counting down may reload old TOP once.
// - Counting up, count and TOP compared continuously; lower new TOP wraps immediately.
// - Retrigger, count and start actions come only from the event input.
// - Capture while channel flag set drops timestamp and sets error flag.
// - Pulse-then-period stores period in value 1; period-then-pulse swaps.
// - Period capture uses both edges, restarts on rising (falling if inverted).
// - Single run stops at next wrap, sets stopped bit, zeroes outputs.
// - Set register enables single run, clear register disables it.
// - Retrigger command, retrigger or start event restarts and clears stopped.
// - Overflow DMA request pulses one clock on each wrap.
// - Channel DMA pulses on match; capture request holds until value read.
// - Two channel DMA lines plus overflow request.
// - DMA-written values act on the next clock; passed values give no match.
// - Compare value written beyond count may match again before wrap.
// - Flags overflow, match, error, sync ready; enable set/clear registers.
// - Interrupt asserted while any enabled flag is set.
// - One shared interrupt line; software reads the flag register.
// - Retrigger reloads or clears while running, resumes when stopped.
// - Match sets channel flag on the next clock edge.
module tmpc_top #(
  parameter int W = 8
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 event_in,
  output logic      [1:0]           waveform_output,
  output tmpc_pkg::tmpc_dma_s       dma_req,
  output logic                      ovf_event,
  output logic      [1:0]           mc_event,
  output logic                      irq
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [2:0]   ctrla_r;
  logic [2:0]   ctrlb_r;
  logic [1:0]   capture_channel_enable_r;
  logic [5:0]   evctrl_r;
  logic [4:0]   ien_r;
  logic [5:0]   iflag_r;
  logic [5:0]   iflag_nxt;
  logic         stop_r;
  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;
  logic [W-1:0] period_r;
  logic [W-1:0] cc_r [2];
  logic [1:0]   cap_valid_r;
  logic [1:0]   wo_r;
  logic         ev_s1_r;
  logic         ev_s2_r;
  logic         ev_d_r;
  logic         sync_pend_r;

  // ----------------------------------------------------------------
  // Interrupt source packing: flag bit 2 has no source behind it
  // ----------------------------------------------------------------
  function automatic logic [4:0] pack_src(input logic [5:0] v);
    pack_src = {v[5:3], v[1:0]};
  endfunction

  function automatic logic [5:0] unpack_src(input logic [4:0] v);
    unpack_src = {v[4:2], 1'b0, v[1:0]};
  endfunction

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Writes and read side effects act once, at the edge that completes the access
  wire        acc       = psel & penable & pready;
  wire        wr        = acc & pwrite;
  wire        rd        = acc & ~pwrite;
  wire        mapped    = (paddr[1:0] == 2'h0) && (paddr <= tmpc_pkg::OFF_CCV1);
  wire        wr_ctrla  = wr && paddr == tmpc_pkg::OFF_CTRLA;
  wire        wr_bclr   = wr && paddr == tmpc_pkg::OFF_CTRL_CLR;
  wire        wr_bset   = wr && paddr == tmpc_pkg::OFF_CTRL_SET;
  wire        wr_ctrlc  = wr && paddr == tmpc_pkg::OFF_CTRLC;
  wire        wr_ev     = wr && paddr == tmpc_pkg::OFF_EVCTRL;
  wire        wr_iclr   = wr && paddr == tmpc_pkg::OFF_IEN_CLR;
  wire        wr_iset   = wr && paddr == tmpc_pkg::OFF_IEN_SET;
  wire        wr_flag   = wr && paddr == tmpc_pkg::OFF_IFLAG;
  wire        wr_count  = wr && paddr == tmpc_pkg::OFF_COUNT;
  wire        wr_period = wr && paddr == tmpc_pkg::OFF_PERIOD;
  wire [1:0]  wr_cc     = {wr && paddr == tmpc_pkg::OFF_CCV1, wr && paddr == tmpc_pkg::OFF_CCV0};
  wire [1:0]  rd_cc     = {rd && paddr == tmpc_pkg::OFF_CCV1, rd && paddr == tmpc_pkg::OFF_CCV0};
  wire [1:0]  cmd_w     = pwdata[tmpc_pkg::CTRLB_CMD_LO +: 2];

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  wire                  enabled  = ctrla_r[tmpc_pkg::CTRLA_EN];
  tmpc_pkg::tmpc_wave_e wave;
  assign wave = tmpc_pkg::tmpc_wave_e'(ctrla_r[tmpc_pkg::CTRLA_WAVE_LO +: 2]);
  wire                  dir_down = ctrlb_r[tmpc_pkg::CTRLB_DIR];
  wire                  single   = ctrlb_r[tmpc_pkg::CTRLB_SINGLE];
  wire [2:0]            act      = evctrl_r[tmpc_pkg::EV_ACT_LO +: 3];
  wire                  ev_en    = evctrl_r[tmpc_pkg::EV_IN_EN];
  wire                  ev_inv   = evctrl_r[tmpc_pkg::EV_INV];
  wire                  match_md = (wave == tmpc_pkg::match_frequency_mode) ||
                                   (wave == tmpc_pkg::match_pwm_mode);
  wire [W-1:0]          top      = match_md ? cc_r[0] : period_r;

  // ----------------------------------------------------------------
  // Event input: synchronised, then edge detected
  // ----------------------------------------------------------------
  wire lvl      = ev_s2_r ^ ev_inv;
  wire ev_rise  = ev_en & lvl & ~ev_d_r;
  wire ev_fall  = ev_en & ~lvl & ev_d_r;
  // Edges show two clocks after the pin, through the two sync flops; the edge flop only holds the last level
  wire ev_ret   = ev_rise && act == tmpc_pkg::ACT_RETRIG;
  wire ev_start = ev_rise && act == tmpc_pkg::ACT_START;
  wire ev_cnt   = ev_rise && act == tmpc_pkg::ACT_COUNT;
  wire ppw_md   = act == tmpc_pkg::ACT_PPW || act == tmpc_pkg::ACT_PWP;

  // ----------------------------------------------------------------
  // Counting
  // ----------------------------------------------------------------
  wire sw_ret  = wr_bset && cmd_w == tmpc_pkg::CMD_RETRIG;
  wire sw_stop = wr_bset && cmd_w == tmpc_pkg::CMD_STOP;
  wire restart = sw_ret | ev_ret | (ev_start & stop_r);
  wire running = enabled & ~stop_r;
  wire tick    = running & (act == tmpc_pkg::ACT_COUNT ? ev_cnt : 1'b1);
  // Unsigned >= catches a TOP written below the count, so it wraps at once
  wire at_end  = dir_down ? (count_r == '0) : (count_r >= top);
  wire wrap    = tick & at_end;
  // Period capture restarts the count on the restart edge, before anything but a bus write to the count
  wire ppw_rst = ppw_md & running & ev_rise;

  always_comb
  begin
    count_nxt = count_r;
    if (ppw_rst)
      count_nxt = '0;
    else if (running && (sw_ret || ev_ret))
      count_nxt = dir_down ? top : '0;
    else if (wrap)
      count_nxt = dir_down ? top : '0;
    else if (tick)
      count_nxt = dir_down ? count_r - W'(1) : count_r + W'(1);
    // A bus write to the count beats count, clear and reload
    if (wr_count)
      count_nxt = pwdata[W-1:0];
  end

  // ----------------------------------------------------------------
  // Compare and capture per channel
  // ----------------------------------------------------------------
  logic [1:0] match;
  logic [1:0] cap_ev;
  logic [1:0] cap_ok;
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_ch
      // Period lands in value 1 for pulse-then-period, swapped otherwise
      wire per_here = (act == tmpc_pkg::ACT_PWP) ? (g == 1) : (g == 0);
      // A channel set to capture never compares
      assign match[g]  = running & tick & ~capture_channel_enable_r[g] & (count_r == cc_r[g]);
      assign cap_ev[g] = capture_channel_enable_r[g] & running &
                         (ppw_md ? (per_here ? ev_rise : ev_fall)
                                 : ev_rise);
      assign cap_ok[g] = cap_ev[g] & ~iflag_r[tmpc_pkg::IF_MC0+g];
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          cc_r[g] <= tmpc_pkg::RST_ZERO8[W-1:0];
        else if (cap_ok[g])
          cc_r[g] <= count_r;
        else if (wr_cc[g])
          cc_r[g] <= pwdata[W-1:0];
      end
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          cap_valid_r[g] <= 1'b0;
        else if (cap_ok[g])
          cap_valid_r[g] <= 1'b1;
        else if (rd_cc[g])
          cap_valid_r[g] <= 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Flags: hardware set wins over a software clear
  // ----------------------------------------------------------------
  wire [5:0] set_v = {match | cap_ok, sync_pend_r, 1'b0, |(cap_ev & ~cap_ok), wrap};
  wire [5:0] clr_v = wr_flag ? pwdata[5:0] : 6'h00;
  assign iflag_nxt = (iflag_r & ~clr_v) | set_v;

  // ----------------------------------------------------------------
  // Waveforms
  // ----------------------------------------------------------------
  logic [1:0] wo_nxt;
  always_comb
  begin
    wo_nxt = wo_r;
    case (wave)
      tmpc_pkg::match_pwm_mode:
      begin
        wo_nxt[0] = ~wrap;
        if (match[1] | wrap)
          wo_nxt[1] = ~wo_r[1];
      end
      tmpc_pkg::match_frequency_mode:
      begin
        if (wrap)
          wo_nxt[0] = ~wo_r[0];
        if (match[1])
          wo_nxt[1] = ~wo_r[1];
      end
      tmpc_pkg::normal_pwm_mode:
      begin
        for (int i = 0; i < 2; i++)
          if (wrap)
            wo_nxt[i] = ~dir_down;
          else if (match[i])
            wo_nxt[i] = dir_down;
      end
      default:
      begin
        for (int i = 0; i < 2; i++)
          if (match[i])
            wo_nxt[i] = ~wo_r[i];
      end
    endcase
    if (stop_r | (wrap & single) | sw_stop)
      wo_nxt = 2'b00;
  end

  // ----------------------------------------------------------------
  // Sequential state
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ev_s1_r <= 1'b0;
      ev_s2_r <= 1'b0;
      ev_d_r  <= 1'b0;
    end
    else
    begin
      ev_s1_r <= event_in;
      ev_s2_r <= ev_s1_r;
      ev_d_r  <= lvl;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrla_r  <= '0;
      ctrlb_r  <= '0;
      capture_channel_enable_r  <= '0;
      evctrl_r <= '0;
      ien_r    <= '0;
      period_r <= tmpc_pkg::RST_PERIOD[W-1:0];
    end
    else
    begin
      if (wr_ctrla)
        ctrla_r <= pwdata[2:0];
      if (wr_bset)
        ctrlb_r <= ctrlb_r | pwdata[2:0];
      else if (wr_bclr)
        ctrlb_r <= ctrlb_r & ~pwdata[2:0];
      if (wr_ctrlc)
        capture_channel_enable_r <= pwdata[5:4];
      if (wr_ev)
        evctrl_r <= pwdata[5:0];
      if (wr_iset)
        ien_r <= ien_r | pack_src(pwdata[5:0]);
      else if (wr_iclr)
        ien_r <= ien_r & ~pack_src(pwdata[5:0]);
      if (wr_period)
        period_r <= pwdata[W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_r     <= tmpc_pkg::RST_ZERO8[W-1:0];
      iflag_r     <= '0;
      stop_r      <= 1'b0;
      sync_pend_r <= 1'b0;
      wo_r        <= 2'b00;
    end
    else
    begin
      count_r     <= count_nxt;
      iflag_r     <= iflag_nxt;
      // One sync ready pulse per accepted write
      sync_pend_r <= wr & ~sync_pend_r;
      wo_r        <= wo_nxt;
      // Restart beats a stop in the same cycle, so no retrigger is lost
      if (restart)
        stop_r <= 1'b0;
      else if ((wrap & single) | sw_stop)
        stop_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all registered
  // ----------------------------------------------------------------
  wire [31:0] rmux =
    paddr == tmpc_pkg::OFF_CTRLA    ? {29'h0, ctrla_r} :
    paddr == tmpc_pkg::OFF_CTRL_SET ? {29'h0, ctrlb_r} :
    paddr == tmpc_pkg::OFF_CTRL_CLR ? {29'h0, ctrlb_r} :
    paddr == tmpc_pkg::OFF_CTRLC    ? {26'h0, capture_channel_enable_r, 4'h0} :
    paddr == tmpc_pkg::OFF_EVCTRL   ? {26'h0, evctrl_r} :
    paddr == tmpc_pkg::OFF_IEN_SET  ? {26'h0, unpack_src(ien_r)} :
    paddr == tmpc_pkg::OFF_IEN_CLR  ? {26'h0, unpack_src(ien_r)} :
    paddr == tmpc_pkg::OFF_IFLAG    ? {26'h0, iflag_r} :
    paddr == tmpc_pkg::OFF_STATUS   ? {28'h0, stop_r, 3'h0} :
    paddr == tmpc_pkg::OFF_COUNT    ? 32'(count_r) :
    paddr == tmpc_pkg::OFF_PERIOD   ? 32'(period_r) :
    paddr == tmpc_pkg::OFF_CCV0     ? 32'(cc_r[0]) :
    paddr == tmpc_pkg::OFF_CCV1     ? 32'(cc_r[1]) : 32'h0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata          <= 32'h0;
      pready          <= 1'b0;
      pslverr         <= 1'b0;
      waveform_output <= 2'b00;
      dma_req         <= '0;
      ovf_event       <= 1'b0;
      mc_event        <= 2'b00;
      irq             <= 1'b0;
    end
    else
    begin
      // One wait state: pready rises in the second access cycle
      pready          <= psel & penable & ~pready;
      pslverr         <= psel & penable & ~pready & ~mapped;
      prdata          <= (psel & ~pwrite) ? rmux : 32'h0;
      waveform_output <= wo_nxt;
      dma_req.ovf     <= wrap;
      // Capture channels hold until read, compare channels pulse
      dma_req.chan    <= (cap_valid_r & ~rd_cc) | cap_ok | match;
      ovf_event       <= wrap;
      mc_event        <= match | cap_ok;
      irq             <= |(pack_src(iflag_nxt) & ien_r);
    end
  end

endmodule // tmpc_top

// file: test/tmpc_evnet.sv
// Event network model: square wave on the event line of the timer
`timescale 1ns/1ps
module tmpc_evnet (
  input  wire logic       pclk,
  input  wire logic       run,
  input  wire logic [7:0] hi_len,
  input  wire logic [7:0] lo_len,
  output logic            event_in
);
  logic [7:0] cnt_r = 8'h00;
  // ----
  // Wave source
  // ----
  // Sole driver of the event line; software never reaches it
  always @(posedge pclk)
  begin
    if (!run)
    begin
      event_in <= 1'b0;
      cnt_r    <= 8'h00;
    end
    else if (cnt_r == 8'h00)
    begin
      event_in <= !event_in;
      cnt_r    <= (event_in ? lo_len : hi_len) - 8'h01;
    end
    else
      cnt_r <= cnt_r - 8'h01;
  end
endmodule // tmpc_evnet

// file: test/tmpc_monitor.sv
// Port checker for the timer block and its bind
`timescale 1ns/1ps
module tmpc_monitor (
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [7:0]          paddr,
  input wire logic [31:0]         pwdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire tmpc_pkg::tmpc_dma_s dma_req,
  input wire logic                ovf_event,
  input wire logic [1:0]          mc_event,
  input wire logic                irq
);
  logic       acc;
  logic [1:0] cap_r;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----
  // Capture enables, tracked so compare and capture requests are told apart
  // ----
  assign acc = psel && penable && pready;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cap_r <= 2'h0;
    else if (acc && pwrite && paddr == tmpc_pkg::OFF_CTRLC)
      cap_r <= pwdata[5:4];
  end
  // ----
  // Assertions
  // ----
  a_ready_wait : assert property (psel && !penable |-> ##2 pready)
    else $error("pready not in second access cycle");
  a_ready_pulse : assert property (pready |=> !pready)
    else $error("pready held over one cycle");
  a_err_ready : assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_ovf_dma_pair : assert property (
    ovf_event |-> dma_req.ovf)
    else $error("wrap event without dma request");
  a_ovf_dma_pulse : assert property (
    $rose(dma_req.ovf) |=> $fell(dma_req.ovf))
    else $error("overflow dma request not one cycle");
  a_irq_masked : assert property (
    acc && pwrite && paddr == tmpc_pkg::OFF_IEN_CLR && pwdata[7:0] == 8'h3B |-> ##2 !irq)
    else $error("irq up with all sources disabled");
  a_cap_dma_hold : assert property (
    cap_r[0] && dma_req.chan[0] && !(psel && !pwrite && paddr == tmpc_pkg::OFF_CCV0)
    |=> dma_req.chan[0])
    else $error("capture dma request dropped before read");
  a_cmp_dma_pulse : assert property (
    !cap_r[1] && dma_req.chan[1] |=> !dma_req.chan[1])
    else $error("compare dma request longer than one cycle");
  a_mc_dma_pair : assert property (
    mc_event[1] |-> dma_req.chan[1])
    else $error("channel event without dma request");
endmodule // tmpc_monitor

bind tmpc_top tmpc_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .dma_req(dma_req), .ovf_event(ovf_event), .mc_event(mc_event), .irq(irq)
);

// file: test/tmpc_top_tb.sv
// Self-checking bench for the timer block
`timescale 1ns/1ps
module tmpc_top_tb;
  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
    logic        e;
  } tmpc_row_s;
  typedef struct packed {
    logic [2:0]  act;
    logic        inv;
    logic [31:0] e0;
    logic [31:0] e1;
  } tmpc_cap_s;
  logic                pclk;
  logic                presetn;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [7:0]          paddr;
  logic [31:0]         pwdata;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic                event_in;
  logic [1:0]          waveform_output;
  tmpc_pkg::tmpc_dma_s dma_req;
  logic                ovf_event;
  logic [1:0]          mc_event;
  logic                irq;
  logic                run = 1'b0;
  logic [31:0]         rd;
  logic [31:0]         c;
  logic                err;
  int                  n_mismatch = 0;
  int                  checked = 0;
  int                  cyc = 0;
  int                  g;
  int                  lo;
  int                  tr;
  tmpc_row_s           rows [9];
  tmpc_cap_s           caps [3];

  tmpc_top #(.W(8)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .event_in(event_in), .waveform_output(waveform_output), .dma_req(dma_req),
    .ovf_event(ovf_event), .mc_event(mc_event), .irq(irq)
  );
  tmpc_evnet u_ev (.pclk(pclk), .run(run), .hi_len(8'h0A), .lo_len(8'h1E), .event_in(event_in));
  // ----
  // Helpers
  // ----
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic near(input logic [31:0] got, input logic [31:0] exp);
    chk((got + 32'h1 >= exp && got <= exp + 32'h1) ? exp : got, exp);
  endtask
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic wait_ovf();
    @(negedge pclk);
    while (ovf_event !== 1'b1)
      @(negedge pclk);
  endtask
  // Cycles between wraps, low cycles of output 0, changes of output 1
  task automatic gap(output int n, output int l, output int t);
    logic p;
    n = 0;
    l = 0;
    t = 0;
    wait_ovf();
    p = waveform_output[1];
    do
    begin
      @(negedge pclk);
      n++;
      l += int'(waveform_output[0] === 1'b0);
      t += int'(waveform_output[1] !== p);
      p = waveform_output[1];
    end
    while (ovf_event !== 1'b1);
  endtask
  // ----
  // Clock and watchdog
  // ----
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end
  // ----
  // Tests
  // ----
  initial
  begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    rows = '{
      '{1'b0, 8'h28, 32'hFF, 1'b0}, '{1'b0, 8'h00, 32'h0, 1'b0}, '{1'b0, 8'h24, 32'h0, 1'b0},
      '{1'b0, 8'h30, 32'h0, 1'b0}, '{1'b0, 8'h34, 32'h0, 1'b1}, '{1'b1, 8'h28, 32'h20, 1'b0},
      '{1'b0, 8'h28, 32'h20, 1'b0}, '{1'b1, 8'h34, 32'h55, 1'b1}, '{1'b0, 8'h28, 32'h20, 1'b0}};
    caps = '{'{3'h5, 1'b0, 32'h0A, 32'h28}, '{3'h4, 1'b0, 32'h28, 32'h0A},
             '{3'h5, 1'b1, 32'h1E, 32'h28}};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w)
        chk(rd, rows[i].d);
      chk({31'h0, err}, {31'h0, rows[i].e});
    end
    $display("registers done");
    wr(8'h2C, 32'h10);
    wr(8'h30, 32'h08);
    for (int m = 0; m < 4; m++)
    begin
      wr(8'h00, 32'h0);
      wr(8'h00, {29'h0, 2'(m), 1'b1});
      gap(g, lo, tr);
      chk(g, m[0] ? 32'h11 : 32'h21);
      if (m == 3)
      begin
        chk(lo, 32'h1);
        chk(tr, 32'h2);
      end
    end
    wr(8'h00, 32'h1);
    wr(8'h08, 32'h1);
    gap(g, lo, tr);
    chk(g, 32'h21);
    wr(8'h04, 32'h1);
    wr(8'h28, 32'h80);
    wait_ovf();
    repeat (96) @(posedge pclk);
    wr(8'h28, 32'h10);
    g = 0;
    while (ovf_event !== 1'b1 && g < 40)
    begin
      @(negedge pclk);
      g++;
    end
    chk(32'(g < 12), 32'h1);
    $display("wave modes done");
    wr(8'h00, 32'h7);
    wr(8'h08, 32'h4);
    wait_ovf();
    repeat (4) @(posedge pclk);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, rd[3]}, 32'h1);
    chk({30'h0, waveform_output}, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    c = rd;
    apb(1'b0, 8'h24, 32'h0);
    chk(rd, c);
    wr(8'h08, 32'h40);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, rd[3]}, 32'h0);
    wr(8'h04, 32'h4);
    gap(g, lo, tr);
    chk(g, 32'h11);
    $display("single run done");
    wr(8'h18, 32'h1);
    wait_ovf();
    wr(8'h00, 32'h0);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, 8'h1C, 32'h0);
    chk({31'h0, rd[0]}, 32'h1);
    wr(8'h1C, 32'h1);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    wr(8'h18, 32'h8);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    wr(8'h14, 32'h3B);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    $display("interrupts done");
    wr(8'h28, 32'hFF);
    foreach (caps[i])
    begin
      wr(8'h00, 32'h0);
      wr(8'h0C, 32'h30);
      wr(8'h10, {26'h0, 1'b1, caps[i].inv, 1'b0, caps[i].act});
      wr(8'h00, 32'h1);
      run <= 1'b1;
      repeat (120) @(posedge pclk);
      wr(8'h1C, 32'h33);
      repeat (80) @(posedge pclk);
      run <= 1'b0;
      repeat (8) @(posedge pclk);
      apb(1'b0, 8'h2C, 32'h0);
      near(rd, caps[i].e0);
      apb(1'b0, 8'h30, 32'h0);
      near(rd, caps[i].e1);
      apb(1'b0, 8'h1C, 32'h0);
      chk({31'h0, rd[1]}, 32'h1);
    end
    $display("capture done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({29'h0, irq, waveform_output}, 32'h0);
    presetn <= 1'b1;
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h28, 32'h0);
    chk(rd, 32'hFF);
    $display("reset done");
    wrap_up();
  end
endmodule // tmpc_top_tb
